// ===== hw/sptl_pkg.sv
package sptl_pkg;

  // ---------------------------------------------------------------
  // Register map (byte offsets on the plain register port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFS    = 4'h0;
  localparam logic [3:0]  STATUS_OFS  = 4'h4;
  localparam logic [3:0]  MASK_OFS    = 4'h8;
  localparam logic [3:0]  ALARM_OFS   = 4'hC;

  // CTRL fields
  localparam int          CTRL_WRAP_BIT = 0;
  localparam logic        CTRL_WRAP_RST = 1'b0;

  // ALARM register fields
  localparam int          ALM_CODE_LSB  = 0;
  localparam int          ALM_ACT_BIT   = 8;
  localparam int          ALM_LOCK_BIT  = 9;
  localparam int          ALM_SCL_LSB   = 16;
  localparam int          ALM_OVF_BIT   = 22;

  // ---------------------------------------------------------------
  // Event bits, shared by STATUS and MASK
  // ---------------------------------------------------------------
  localparam int          SCALE_BITS  = 6;
  localparam int          EV_W        = 10;
  localparam int          EV_HOME     = 6;
  localparam int          EV_UNDEF    = 7;
  localparam int          EV_OVF      = 8;
  localparam int          EV_DRIVE    = 9;
  localparam logic [9:0]  STATUS_RST  = 10'h000;
  localparam logic [9:0]  MASK_RST    = 10'h000;

  // ---------------------------------------------------------------
  // Trip codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CODE_NONE       = 8'h00;
  localparam logic [7:0]  CODE_SCALE_BASE = 8'h32;
  localparam logic [7:0]  CODE_HOMING     = 8'h44;
  localparam logic [7:0]  CODE_UNDEF      = 8'h45;
  localparam logic [7:0]  CODE_OVF        = 8'h46;
  localparam logic [7:0]  CODE_DRIVE      = 8'h47;

  // ---------------------------------------------------------------
  // Present position span
  // ---------------------------------------------------------------
  localparam logic [31:0] POS_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] POS_MIN = 32'h8000_0001;
  localparam logic [31:0] POS_RST = 32'h0000_0000;

  typedef enum logic [1:0] {ST_CLEAR, ST_TRIP, ST_LOCK} sptl_alarm_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sptl_bus_req_s;

  typedef struct packed {
    logic start;
    logic active;
    logic error;
    logic done;
    logic param_ok;
  } sptl_home_s;

  typedef struct packed {
    logic cmd;
    logic param_ok;
    logic active;
    logic dir_ccw;
    logic step;
  } sptl_move_s;

endpackage

// ===== hw/sptl_pos_cnt.sv
module sptl_pos_cnt (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        step,
  input  wire logic        dir_up,
  input  wire logic        wrap_accept,
  output logic [31:0]      pos_reg,
  output logic             ovf_reg
);
  import sptl_pkg::*;

  logic at_top;
  logic at_bot;

  assign at_top = (pos_reg == POS_MAX);
  assign at_bot = (pos_reg == POS_MIN);

  // -----------------------------------------------------------------
  // Counter, held at the span edge when wrap is not accepted
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_reg <= POS_RST;
    end else if (step) begin
      if (dir_up && at_top) begin
        if (wrap_accept) begin
          pos_reg <= POS_MIN;
        end
      end else if (!dir_up && at_bot) begin
        if (wrap_accept) begin
          pos_reg <= POS_MAX;
        end
      end else if (dir_up) begin
        pos_reg <= pos_reg + 32'h0000_0001;
      end else begin
        pos_reg <= pos_reg - 32'h0000_0001;
      end
    end
  end

  // One-cycle overflow pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= step && !wrap_accept &&
                 ((dir_up && at_top) || (!dir_up && at_bot));
    end
  end

endmodule

// ===== hw/sptl_top.sv
// Summary of operation
// - Scale and overflow trips ignore alarm clear; others clear by it.
// - Scale fault bit n rising to one raises trip code 50 plus n.
// - Scale status trips stay latched until power-on reset.
// - Homing error, bad inhibit input, or bad homing parameter gives 68.
// - Step or jog commanded with unset or invalid parameter gives 69.
// - Position spans +/-2147483647; overflow without wrap accept gives 70.
// - After homing, inhibit in motion direction during step or jog gives 71.
// - Both over-travel inhibit inputs open together outside homing gives 71.
module sptl_top (
  input  wire logic                   MCLK,
  input  wire logic                   SRST,
  input  wire logic [5:0]             SCALE_FAULT_CODE,
  input  wire logic                   CCW_TRAVEL_INHIBIT,
  input  wire logic                   CW_TRAVEL_INHIBIT,
  input  wire logic                   ALARM_CLEAR,
  input  wire sptl_pkg::sptl_home_s   HOMING,
  input  wire sptl_pkg::sptl_move_s   MOTION,
  input  wire sptl_pkg::sptl_bus_req_s BUS,
  output logic [31:0]                 RDATA,
  output logic [31:0]                 POSITION,
  output logic [7:0]                  ERR_CODE,
  output logic                        ALARM,
  output logic                        ALARM_LOCKED,
  output logic                        IRQ
);
  import sptl_pkg::*;

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  sptl_alarm_e        state_reg;
  sptl_alarm_e        state_next;
  logic [5:0]         scale_prev_reg;
  logic [5:0]         scale_rise;
  logic [5:0]         scale_latch_reg;
  logic               ovf_latch_reg;
  logic               ovf_pulse;
  logic               wrap_reg;
  logic [EV_W-1:0]    status_reg;
  logic [EV_W-1:0]    mask_reg;
  logic [EV_W-1:0]    ev;
  logic [7:0]         code_reg;
  logic [7:0]         code_next;
  logic               both_open;
  logic               dir_inhibit;
  logic               ev_home;
  logic               ev_undef;
  logic               ev_drive;
  logic               any_ev;
  logic               nonclr_ev;
  logic               load_code;
  logic               rd_status;

  // -----------------------------------------------------------------
  // Scale status edge detect and latch
  // -----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      scale_prev_reg <= 6'h00;
    end else begin
      scale_prev_reg <= SCALE_FAULT_CODE;
    end
  end

  generate
    for (genvar i = 0; i < SCALE_BITS; i++) begin : g_scale
      assign scale_rise[i] = SCALE_FAULT_CODE[i] && !scale_prev_reg[i];
      // Only a reset releases the latch
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          scale_latch_reg[i] <= 1'b0;
        end else if (scale_rise[i]) begin
          scale_latch_reg[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Position counter
  // -----------------------------------------------------------------
  sptl_pos_cnt u_pos (
    .clk         (MCLK),
    .rst         (SRST),
    .step        (MOTION.step),
    .dir_up      (MOTION.dir_ccw),
    .wrap_accept (wrap_reg),
    .pos_reg     (POSITION),
    .ovf_reg     (ovf_pulse)
  );

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ovf_latch_reg <= 1'b0;
    end else if (ovf_pulse) begin
      ovf_latch_reg <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Fault detection
  // -----------------------------------------------------------------
  assign both_open   = CCW_TRAVEL_INHIBIT && CW_TRAVEL_INHIBIT;
  assign dir_inhibit = MOTION.dir_ccw ? CCW_TRAVEL_INHIBIT
                                      : CW_TRAVEL_INHIBIT;

  // A bad inhibit pair during homing is a homing fault, not a drive fault
  assign ev_home  = (HOMING.active && HOMING.error) ||
                    (HOMING.active && both_open) ||
                    (HOMING.start && !HOMING.param_ok);
  assign ev_undef = MOTION.cmd && !MOTION.param_ok;
  assign ev_drive = (HOMING.done && MOTION.active && dir_inhibit) ||
                    (both_open && !HOMING.active);

  always_comb begin
    ev           = '0;
    ev[5:0]      = scale_rise;
    ev[EV_HOME]  = ev_home;
    ev[EV_UNDEF] = ev_undef;
    ev[EV_OVF]   = ovf_pulse;
    ev[EV_DRIVE] = ev_drive;
  end

  assign any_ev    = |ev;
  assign nonclr_ev = (|scale_rise) || ovf_pulse;

  // Simultaneous faults: scale lowest bit, overflow, homing, data, drive
  always_comb begin
    code_next = CODE_NONE;
    if (ev_drive) begin
      code_next = CODE_DRIVE;
    end
    if (ev_undef) begin
      code_next = CODE_UNDEF;
    end
    if (ev_home) begin
      code_next = CODE_HOMING;
    end
    if (ovf_pulse) begin
      code_next = CODE_OVF;
    end
    for (int i = SCALE_BITS - 1; i >= 0; i--) begin
      if (scale_rise[i]) begin
        code_next = CODE_SCALE_BASE + 8'(i);
      end
    end
  end

  // -----------------------------------------------------------------
  // Alarm state
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CLEAR: begin
        if (nonclr_ev) begin
          state_next = ST_LOCK;
        end else if (any_ev) begin
          state_next = ST_TRIP;
        end
      end
      ST_TRIP: begin
        if (nonclr_ev) begin
          state_next = ST_LOCK;
        end else if (ALARM_CLEAR && !any_ev) begin
          state_next = ST_CLEAR;
        end
      end
      ST_LOCK: begin
        state_next = ST_LOCK;
      end
      default: begin
        state_next = ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_reg <= ST_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  // A fault in the clearing cycle starts a fresh alarm, not lost
  assign load_code = any_ev &&
                     ((state_reg == ST_CLEAR) ||
                      (state_reg == ST_TRIP && ALARM_CLEAR && !nonclr_ev));

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      code_reg <= CODE_NONE;
    end else if (load_code) begin
      code_reg <= code_next;
    end else if (state_next == ST_CLEAR) begin
      code_reg <= CODE_NONE;
    end
  end

  assign ERR_CODE     = code_reg;
  assign ALARM        = (state_reg != ST_CLEAR);
  assign ALARM_LOCKED = (state_reg == ST_LOCK);

  // -----------------------------------------------------------------
  // Register port
  // -----------------------------------------------------------------
  assign rd_status = BUS.rd && (BUS.addr == STATUS_OFS);

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wrap_reg <= CTRL_WRAP_RST;
    end else if (BUS.wr && BUS.addr == CTRL_OFS) begin
      wrap_reg <= BUS.wdata[CTRL_WRAP_BIT];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mask_reg <= MASK_RST;
    end else if (BUS.wr && BUS.addr == MASK_OFS) begin
      mask_reg <= BUS.wdata[EV_W-1:0];
    end
  end

  // Read clears; a new event in the same cycle survives the clear
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      status_reg <= STATUS_RST;
    end else if (rd_status) begin
      status_reg <= ev;
    end else begin
      status_reg <= status_reg | ev;
    end
  end

  assign IRQ = |(status_reg & mask_reg);

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else if (!BUS.rd) begin
      RDATA <= 32'h0000_0000;
    end else if (BUS.addr == CTRL_OFS) begin
      RDATA <= {31'h0000_0000, wrap_reg};
    end else if (BUS.addr == STATUS_OFS) begin
      RDATA <= {22'h00_0000, status_reg};
    end else if (BUS.addr == MASK_OFS) begin
      RDATA <= {22'h00_0000, mask_reg};
    end else if (BUS.addr == ALARM_OFS) begin
      RDATA <= {9'h000, ovf_latch_reg, scale_latch_reg, 6'h00,
                ALARM_LOCKED, ALARM, code_reg};
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  logic no_hi_home;
  logic no_hi_undef;
  logic no_hi_drive;

  assign no_hi_home  = !(|scale_rise) && !ovf_pulse;
  assign no_hi_undef = no_hi_home && !ev_home;
  assign no_hi_drive = no_hi_undef && !ev_undef;

  sequence s_idle_scale0;
    state_reg == ST_CLEAR && scale_rise[0];
  endsequence

  sequence s_tripped_clear;
    state_reg == ST_TRIP && ALARM_CLEAR && !any_ev;
  endsequence

  sequence s_ovf_at_top;
    !wrap_reg && MOTION.step && MOTION.dir_ccw && POSITION == POS_MAX;
  endsequence

  a_scale_code: assert property (@(posedge MCLK) disable iff (SRST)
    s_idle_scale0 |=> ERR_CODE == CODE_SCALE_BASE && ALARM_LOCKED)
    else $error("scale bit 0 did not raise its code");

  a_scale_hold: assert property (@(posedge MCLK) disable iff (SRST)
    scale_latch_reg[5] |=> scale_latch_reg[5] && ALARM)
    else $error("scale latch released without reset");

  a_lock_ignores: assert property (@(posedge MCLK) disable iff (SRST)
    ALARM_LOCKED && ALARM_CLEAR |=> ALARM_LOCKED && $stable(ERR_CODE))
    else $error("locked trip cleared by alarm clear");

  a_clear_works: assert property (@(posedge MCLK) disable iff (SRST)
    s_tripped_clear |=> !ALARM && ERR_CODE == CODE_NONE)
    else $error("clearable trip not cleared");

  a_home_param: assert property (@(posedge MCLK) disable iff (SRST)
    state_reg == ST_CLEAR && HOMING.start && !HOMING.param_ok &&
    no_hi_home |=> ERR_CODE == CODE_HOMING && ALARM && !ALARM_LOCKED)
    else $error("homing parameter fault not reported");

  a_home_error: assert property (@(posedge MCLK) disable iff (SRST)
    state_reg == ST_CLEAR && HOMING.active && HOMING.error &&
    no_hi_home |=> ERR_CODE == CODE_HOMING && ALARM)
    else $error("homing sequence fault not reported");

  a_undef_data: assert property (@(posedge MCLK) disable iff (SRST)
    state_reg == ST_CLEAR && MOTION.cmd && !MOTION.param_ok &&
    no_hi_undef |=> ERR_CODE == CODE_UNDEF)
    else $error("undefined data fault not reported");

  // Span edges lie far beyond any short run; kept as a guard for long ones
  a_ovf_trip: assert property (@(posedge MCLK) disable iff (SRST)
    s_ovf_at_top |=> POSITION == POS_MAX ##1 ALARM_LOCKED)
    else $error("position overflow not trapped");

  a_drive_dir: assert property (@(posedge MCLK) disable iff (SRST)
    state_reg == ST_CLEAR && HOMING.done && MOTION.active &&
    MOTION.dir_ccw && CCW_TRAVEL_INHIBIT && no_hi_drive
    |=> ERR_CODE == CODE_DRIVE)
    else $error("inhibit in motion direction not reported");

  a_drive_cw: assert property (@(posedge MCLK) disable iff (SRST)
    state_reg == ST_CLEAR && HOMING.done && MOTION.active &&
    !MOTION.dir_ccw && CW_TRAVEL_INHIBIT && no_hi_drive
    |=> ERR_CODE == CODE_DRIVE)
    else $error("cw inhibit in motion direction not reported");

  a_both_open: assert property (@(posedge MCLK) disable iff (SRST)
    state_reg == ST_CLEAR && both_open && !HOMING.active &&
    no_hi_drive |=> ERR_CODE == CODE_DRIVE && ALARM)
    else $error("both inhibits open not reported");

  a_code_held: assert property (@(posedge MCLK) disable iff (SRST)
    ALARM && !ALARM_CLEAR |=> ALARM && $stable(ERR_CODE))
    else $error("alarm code changed while held");

  // Read data must not linger, or software would see stale words
  a_rdata_idle: assert property (@(posedge MCLK) disable iff (SRST)
    !BUS.rd |=> RDATA == 32'h0000_0000)
    else $error("read data present without a read");

  // Set wins over the read clear, so no event is lost
  a_status_clear: assert property (@(posedge MCLK) disable iff (SRST)
    rd_status |=> status_reg == $past(ev))
    else $error("status read did not clear to new events");

endmodule

// ===== tb/servo_protection_trip_logic_tb_top.sv
module servo_protection_trip_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sptl_pkg::*;

  logic          mclk = 1'b0;
  logic          srst = 1'b1;
  logic          clr  = 1'b0;
  sptl_bus_req_s bus_q = '0;
  logic [5:0]    scale;
  logic          ccw;
  logic          cw;
  sptl_home_s    home;
  sptl_move_s    move;
  logic [31:0]   rdata;
  logic [31:0]   pos;
  logic [7:0]    err_code;
  logic          alarm;
  logic          locked;
  logic          irq;
  int            num_errors = 0;
  int            n_checks = 0;
  logic [31:0]   d;

  initial begin
    forever #4 mclk = ~mclk;
  end

  sptl_host_model host (.clk(mclk), .scale_code(scale), .ccw_inh(ccw),
    .cw_inh(cw), .home(home), .move(move));

  sptl_top uut (.MCLK(mclk), .SRST(srst), .SCALE_FAULT_CODE(scale),
    .CCW_TRAVEL_INHIBIT(ccw), .CW_TRAVEL_INHIBIT(cw), .ALARM_CLEAR(clr),
    .HOMING(home), .MOTION(move), .BUS(bus_q), .RDATA(rdata),
    .POSITION(pos), .ERR_CODE(err_code), .ALARM(alarm),
    .ALARM_LOCKED(locked), .IRQ(irq));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    host.idle();
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    bus_q.wr    <= 1'b1;
    bus_q.addr  <= a;
    bus_q.wdata <= v;
    @(posedge mclk);
    bus_q.wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    bus_q.rd   <= 1'b1;
    bus_q.addr <= a;
    @(posedge mclk);
    bus_q.rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // Trips land a cycle or two after the cause; bounded wait
  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic clear();
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    settle();
  endtask

  task automatic trip(input string nm, input logic [7:0] c);
    settle();
    chk({nm, " alarm"}, 32'h1, {31'h0, alarm});
    chk({nm, " code"}, {24'h0, c}, {24'h0, err_code});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [3:0] ofs [5] = '{CTRL_OFS, STATUS_OFS, MASK_OFS, ALARM_OFS,
                            4'h2};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk("reg reset", 32'h0, d);
    end
    wr(CTRL_OFS, 32'h0000_0001);
    wr(STATUS_OFS, 32'h0000_03FF);
    wr(4'h2, 32'hFFFF_FFFF);
    wr(MASK_OFS, 32'hFFFF_FFFF);
    rd(CTRL_OFS);
    chk("ctrl", 32'h1, d);
    rd(MASK_OFS);
    chk("mask", 32'h0000_03FF, d);
    chk("irq idle", 32'h0, {31'h0, irq});
    wr(MASK_OFS, 32'h0000_0000);
    rd(STATUS_OFS);
    chk("status ro", 32'h0, d);
    rd(4'h2);
    chk("unmapped", 32'h0, d);
  endtask

  task automatic t_pos();
    repeat (3) host.step(1'b1);
    host.step(1'b0);
    settle();
    chk("position", 32'h2, pos);
  endtask

  task automatic t_scale();
    for (int n = 0; n < SCALE_BITS; n++) begin
      do_reset();
      @(posedge mclk);
      host.scale_code <= 6'h01 << n;
      trip("scale", CODE_SCALE_BASE + 8'(n));
      @(posedge mclk);
      host.scale_code <= 6'h00;
      clear();
      chk("scale latched", 32'h1, {31'h0, alarm});
      chk("scale locked", 32'h1, {31'h0, locked});
    end
  endtask

  task automatic t_first();
    do_reset();
    wr(MASK_OFS, 32'h1 << EV_UNDEF);
    host.cmd(1'b1);
    settle();
    chk("good cmd", 32'h0, {31'h0, alarm});
    host.cmd(1'b0);
    trip("undef", CODE_UNDEF);
    chk("irq on", 32'h1, {31'h0, irq});
    host.home_bad(1'b1);
    trip("first kept", CODE_UNDEF);
    rd(ALARM_OFS);
    chk("alarm reg", {23'h0, 1'b1, CODE_UNDEF}, d);
    rd(STATUS_OFS);
    chk("status", (32'h1 << EV_UNDEF) | (32'h1 << EV_HOME), d);
    settle();
    chk("irq off", 32'h0, {31'h0, irq});
    clear();
    chk("cleared", 32'h0, {24'h0, err_code});
  endtask

  task automatic t_home();
    for (int k = 0; k < 2; k++) begin
      do_reset();
      host.home_bad(k[0]);
      trip("homing", CODE_HOMING);
      clear();
      chk("homing clr", 32'h0, {31'h0, alarm});
    end
  endtask

  task automatic t_inhibit();
    do_reset();
    @(posedge mclk);
    host.ccw_inh <= 1'b1;
    host.cw_inh  <= 1'b1;
    trip("both open", CODE_DRIVE);
    host.idle();
    clear();
    chk("drive clr", 32'h0, {31'h0, alarm});
    @(posedge mclk);
    host.move.active  <= 1'b1;
    host.move.dir_ccw <= 1'b1;
    host.ccw_inh      <= 1'b1;
    settle();
    chk("not homed", 32'h0, {31'h0, alarm});
    @(posedge mclk);
    host.home.done <= 1'b1;
    trip("travel", CODE_DRIVE);
    do_reset();
    @(posedge mclk);
    host.home.done    <= 1'b1;
    host.move.active  <= 1'b1;
    host.move.dir_ccw <= 1'b0;
    host.cw_inh       <= 1'b1;
    trip("travel cw", CODE_DRIVE);
  endtask

  // ---------------------------------------------------------------
  // Verdict and watchdog
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    print_verdict();
  end

  initial begin
    do_reset();
    t_regs();
    t_pos();
    t_scale();
    t_first();
    t_home();
    t_inhibit();
    print_verdict();
  end
endmodule

// ===== tb/sptl_host_model.sv
module sptl_host_model (
  input  wire logic            clk,
  output logic [5:0]           scale_code,
  output logic                 ccw_inh,
  output logic                 cw_inh,
  output sptl_pkg::sptl_home_s home,
  output sptl_pkg::sptl_move_s move
);
  timeunit 1ns;
  timeprecision 1ps;
  import sptl_pkg::*;

  // ---------------------------------------------------------------
  // Host, limit switches and scale, all idle at time zero
  // ---------------------------------------------------------------
  initial begin
    scale_code = 6'h00;
    ccw_inh    = 1'b0;
    cw_inh     = 1'b0;
    home       = '0;
    move       = '0;
  end

  task automatic idle();
    @(posedge clk);
    scale_code <= 6'h00;
    ccw_inh    <= 1'b0;
    cw_inh     <= 1'b0;
    home       <= '0;
    move       <= '0;
  endtask

  // Pulses last one cycle; level fields stay as left
  task automatic cmd(input logic ok);
    @(posedge clk);
    move.cmd      <= 1'b1;
    move.param_ok <= ok;
    @(posedge clk);
    move.cmd      <= 1'b0;
  endtask

  task automatic step(input logic up);
    @(posedge clk);
    move.step    <= 1'b1;
    move.dir_ccw <= up;
    @(posedge clk);
    move.step    <= 1'b0;
  endtask

  // A homing error only counts while a homing sequence is running
  task automatic home_bad(input logic err);
    @(posedge clk);
    home.active   <= err;
    home.error    <= err;
    home.start    <= !err;
    home.param_ok <= err;
    @(posedge clk);
    home.active   <= 1'b0;
    home.error    <= 1'b0;
    home.start    <= 1'b0;
  endtask
endmodule
